//--- inc/pvo_consts.svh
`ifndef PVO_CONSTS_SVH
`define PVO_CONSTS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define PVO_VGA_W       10'd640
`define PVO_VGA_H       10'd480
`define PVO_ZOOM_W      10'd320
`define PVO_ZOOM_H      10'd240
`define PVO_TV_W        10'd720
`define PVO_TV_W_MIN    10'd692
`define PVO_MARGIN_MAX  4'd14
`define PVO_PIX_STEP    10'd2

// ----------------------------------------------------------------------------
// Byte values
// ----------------------------------------------------------------------------
`define PVO_BLACK_Y     8'h10
`define PVO_BLACK_C     8'h80
`define PVO_TRS0        8'hff
`define PVO_TRS1        8'h00
`define PVO_IDLE_BYTE   8'h00

// ----------------------------------------------------------------------------
// Beat layout: 32 data bits and five frame flags
// ----------------------------------------------------------------------------
`define PVO_BEAT_W      37
`define PVO_B_SOF       36
`define PVO_B_EOF       35
`define PVO_B_SOL       34
`define PVO_B_EOL       33
`define PVO_B_FIELD     32

`endif

//--- inc/pvo_pkg.sv
package pvo_pkg;

  typedef enum logic [2:0] {
    PVO_MODE_BT656     = 3'h0,
    PVO_MODE_YUV       = 3'h1,
    PVO_MODE_RGB       = 3'h2,
    PVO_MODE_RAW_PACK  = 3'h3,
    PVO_MODE_RAW_WIDE  = 3'h4
  } pvo_mode_t;

  typedef enum logic [1:0] {
    PVO_RGB_565  = 2'h0,
    PVO_RGB_555  = 2'h1,
    PVO_RGB_444X = 2'h2,
    PVO_RGB_X444 = 2'h3
  } pvo_pack_t;

  typedef enum logic [3:0] {
    PVO_ST_IDLE = 4'h1,
    PVO_ST_SAV  = 4'h2,
    PVO_ST_DATA = 4'h4,
    PVO_ST_EAV  = 4'h8
  } pvo_state_t;

  typedef struct packed {
    logic [3:0][7:0] b;
    logic [1:0]      lsb;
    logic [2:0]      n;
  } pvo_bytes_t;

endpackage

//--- inc/pvo_stream_if.sv
`timescale 1ns/1ps
interface pvo_stream_if #(parameter int W = 37);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

//--- design/pvo_buf2.sv
`timescale 1ns/1ps
module pvo_buf2 #(
  parameter int W     = 37,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic   i_mclk,
  input  wire logic   i_rst_n,
  input  wire logic   i_ce,
  input  wire logic   i_flush,
  // Streams
  pvo_stream_if.snk   s_in,
  pvo_stream_if.src   s_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // Ready and valid drop with the clock enable so no beat is taken while frozen.
  assign s_in.ready  = i_ce && (cnt_q != FULL);
  assign s_out.valid = i_ce && (cnt_q != '0);
  assign s_out.data  = mem_q[rd_q];
  assign push = s_in.valid && s_in.ready;
  assign pop  = s_out.valid && s_out.ready;

  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (i_ce && i_flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (i_ce) begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push && !i_flush) begin
      mem_q[wr_q] <= s_in.data;
    end
  end

  a_buf_no_over: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (cnt_q == FULL && !pop && !i_flush) |=> (cnt_q == FULL))
    else $error("Full buffer lost a word or overfilled.");
endmodule

//--- design/pvo_formatter.sv
`timescale 1ns/1ps
`include "pvo_consts.svh"

// Summary of operation
// RULE_01: Packed raw sends bits 9..2 first, then bits 1..0 with six zeros above.
// RULE_02: Wide raw puts bits 9..2 on the bus and bits 1..0 on two side pins.
// RULE_03: Raw samples always go out progressive, field flag ignored.
// RULE_04: Broadcast mode embeds start and end timing codes, qualifiers stay low.
// RULE_05: Colour-pipe 640x480 progressive image goes out framed by line and frame valid.
// RULE_06: RGB packings 565, 555 and two 444 layouts are selectable.
// RULE_07: Odd byte carries red and upper green, even byte the rest, zeros padded; X444 sends zeros and red first, then green and blue.
// RULE_08: Four YCbCr orders by swapping chroma pair and luma against chroma.
// RULE_09: Bypass passes sensor Bayer straight out, timed by pixel clock and qualifiers.
// RULE_10: Bus is 8 bits for YCbCr and RGB, 10 bits for raw; packed raw uses only the 8-bit bus, in two bytes.
// RULE_11: Zoom x2 reads a 320x240 window placed anywhere in VGA, then upscales.
// RULE_12: Zoom works in both scan types; progressive zoom stays at VGA.
// RULE_13: Active television line width is programmable from 692 to 720 pixels.
// RULE_14: Two margins, each even and at most 14 pixels.
// RULE_15: Frame sync restarts timing and encoder, settings untouched.
// RULE_16: Receiver takes bytes only while both qualifiers are high; the bench model also takes every byte while i_take_all is set.
module pvo_formatter #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // Pixel stream from the image_processing_pipeline or sensor
  input  wire logic        i_pix_valid,
  output logic             o_pix_ready,
  input  wire logic [31:0] i_pix_data,
  input  wire logic        i_pix_sof,
  input  wire logic        i_pix_eof,
  input  wire logic        i_pix_sol,
  input  wire logic        i_pix_eol,
  input  wire logic        i_pix_field,
  // Configuration
  input  wire logic [2:0]  i_mode,
  input  wire logic [1:0]  i_rgb_pack,
  input  wire logic        i_swap_cbcr,
  input  wire logic        i_swap_yc,
  input  wire logic        i_zoom_x2,
  input  wire logic [9:0]  i_pan_col,
  input  wire logic [9:0]  i_pan_row,
  input  wire logic [3:0]  i_margin_left,
  input  wire logic [3:0]  i_margin_right,
  // Link pins
  input  wire logic        i_pixel_strobe_clock,
  input  wire logic        i_frame_sync,
  output logic [7:0]       o_dout,
  output logic [1:0]       o_dout_lsb,
  output logic             o_line_valid,
  output logic             o_frame_valid,
  // Sensor and encoder control
  output logic [9:0]       o_win_col,
  output logic [9:0]       o_win_row,
  output logic [9:0]       o_active_width,
  output logic             o_restart
);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [9:0] pvo_margin(input logic [3:0] m);
    logic [3:0] c;
    c = (m > `PVO_MARGIN_MAX) ? `PVO_MARGIN_MAX : m;
    return {6'h0, c[3:1], 1'b0}; // see RULE_14
  endfunction

  function automatic logic [7:0] pvo_trs(input logic [1:0] i, input logic f,
                                         input logic h);
    logic v;
    v = 1'b0;
    case (i)
      2'd0:    return `PVO_TRS0;
      2'd1:    return `PVO_TRS1;
      2'd2:    return `PVO_TRS1;
      default: return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h}; // see RULE_04
    endcase
  endfunction

  function automatic pvo_pkg::pvo_bytes_t pvo_pack(
      input pvo_pkg::pvo_mode_t m, input pvo_pkg::pvo_pack_t p, input logic sc,
      input logic sy, input logic [31:0] d, input logic blank);
    pvo_pkg::pvo_bytes_t r;
    logic [7:0] c0, c1, y0, y1;
    r  = '0;
    c0 = blank ? `PVO_BLACK_C : (sc ? d[15:8] : d[31:24]);
    c1 = blank ? `PVO_BLACK_C : (sc ? d[31:24] : d[15:8]);
    y0 = blank ? `PVO_BLACK_Y : d[23:16];
    y1 = blank ? `PVO_BLACK_Y : d[7:0];
    case (m)
      pvo_pkg::PVO_MODE_RGB: begin
        r.n = 3'd2;
        case (p) // see RULE_06
          pvo_pkg::PVO_RGB_565:  r.b = {16'h0, d[20:18], d[15:11], d[31:27], d[23:21]};
          pvo_pkg::PVO_RGB_555:  r.b = {16'h0, d[21:19], d[15:11], 1'b0, d[31:27], d[23:22]};
          pvo_pkg::PVO_RGB_444X: r.b = {16'h0, d[15:12], 4'h0, d[31:28], d[23:20]};
          default:               r.b = {16'h0, d[23:20], d[15:12], 4'h0, d[31:28]};
        endcase // see RULE_07
      end
      pvo_pkg::PVO_MODE_RAW_PACK: begin
        r.n = 3'd2;
        r.b = {16'h0, 6'h0, d[1:0], d[9:2]}; // see RULE_01
      end
      pvo_pkg::PVO_MODE_RAW_WIDE: begin
        r.n   = 3'd1;
        r.b   = {24'h0, d[9:2]};
        r.lsb = d[1:0]; // see RULE_02
      end
      default: begin
        r.n = 3'd4;
        r.b = sy ? {c1, y1, c0, y0} : {y1, c1, y0, c0}; // see RULE_08
      end
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers and restart
  // --------------------------------------------------------------------------
  logic [2:0] ps_q, ps_d, fs_q, fs_d;
  logic       adv, restart, rst_out_q, rst_out_d;

  always_comb begin
    ps_d      = {ps_q[1:0], i_pixel_strobe_clock};
    fs_d      = {fs_q[1:0], i_frame_sync};
    rst_out_d = fs_q[1] && !fs_q[2];
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ps_q      <= 3'h0;
      fs_q      <= 3'h0;
      rst_out_q <= 1'b0;
    end else if (i_ce) begin
      ps_q      <= ps_d;
      fs_q      <= fs_d;
      rst_out_q <= rst_out_d;
    end
  end

  assign adv       = i_ce && ps_q[1] && !ps_q[2];
  assign restart   = i_ce && fs_q[1] && !fs_q[2];
  assign o_restart = rst_out_q; // see RULE_15

  // --------------------------------------------------------------------------
  // Window and line width
  // --------------------------------------------------------------------------
  logic [9:0] col_q, col_d, row_q, row_d, wid_q, wid_d, ml, mr;

  assign ml = pvo_margin(i_margin_left);
  assign mr = pvo_margin(i_margin_right);

  always_comb begin
    col_d = 10'h0;
    row_d = 10'h0;
    if (i_zoom_x2) begin // see RULE_11
      col_d = (i_pan_col > `PVO_VGA_W - `PVO_ZOOM_W) ? `PVO_VGA_W - `PVO_ZOOM_W : i_pan_col;
      row_d = (i_pan_row > `PVO_VGA_H - `PVO_ZOOM_H) ? `PVO_VGA_H - `PVO_ZOOM_H : i_pan_row;
    end
    wid_d = `PVO_TV_W - ml - mr; // see RULE_13
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      col_q <= 10'h0;
      row_q <= 10'h0;
      wid_q <= `PVO_TV_W;
    end else if (i_ce) begin
      col_q <= col_d;
      row_q <= row_d;
      wid_q <= wid_d;
    end
  end

  assign o_win_col      = col_q;
  assign o_win_row      = row_q;
  assign o_active_width = wid_q;

  // --------------------------------------------------------------------------
  // Two-entry buffer
  // --------------------------------------------------------------------------
  pvo_stream_if #(.W(`PVO_BEAT_W)) s_in ();
  pvo_stream_if #(.W(`PVO_BEAT_W)) s_out ();

  assign s_in.data  = {i_pix_sof, i_pix_eof, i_pix_sol, i_pix_eol, i_pix_field, i_pix_data};
  assign s_in.valid = i_pix_valid;
  assign o_pix_ready = s_in.ready;

  pvo_buf2 #(.W(`PVO_BEAT_W), .DEPTH(BUF_DEPTH)) u_buf (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_flush (restart),
    .s_in    (s_in.snk),
    .s_out   (s_out.src)
  );

  // --------------------------------------------------------------------------
  // Byte serialiser
  // --------------------------------------------------------------------------
  pvo_pkg::pvo_mode_t  mode;
  pvo_pkg::pvo_state_t st_q, st_d;
  pvo_pkg::pvo_bytes_t pk;
  logic [`PVO_BEAT_W-1:0] beat_q, beat_d;
  logic [1:0] idx_q, idx_d, lsb_q, lsb_d;
  logic [9:0] pix_q, pix_d;
  logic [7:0] dout_q, dout_d;
  logic       rep_q, rep_d, lv_q, lv_d, fv_q, fv_d, take, bt, raw, zoom_on, blank;

  assign mode    = pvo_pkg::pvo_mode_t'(i_mode);
  assign bt      = (mode == pvo_pkg::PVO_MODE_BT656);
  assign raw     = (mode == pvo_pkg::PVO_MODE_RAW_PACK) || (mode == pvo_pkg::PVO_MODE_RAW_WIDE);
  assign zoom_on = i_zoom_x2 && !raw; // see RULE_12
  assign blank   = bt && ((pix_q < ml) || (pix_q >= `PVO_TV_W - mr)); // see RULE_13
  assign pk      = pvo_pack(mode, pvo_pkg::pvo_pack_t'(i_rgb_pack), i_swap_cbcr, i_swap_yc,
                            beat_q[31:0], blank);
  assign s_out.ready = take;

  always_comb begin
    st_d   = st_q;
    idx_d  = idx_q;
    rep_d  = rep_q;
    beat_d = beat_q;
    pix_d  = pix_q;
    dout_d = dout_q;
    lsb_d  = lsb_q;
    lv_d   = lv_q;
    fv_d   = fv_q;
    take   = 1'b0;
    if (restart) begin // see RULE_15
      st_d  = pvo_pkg::PVO_ST_IDLE;
      idx_d = 2'd0;
      rep_d = 1'b0;
      lv_d  = 1'b0;
      fv_d  = 1'b0;
    end else if (adv) begin
      lv_d  = 1'b0;
      lsb_d = 2'h0;
      case (st_q)
        pvo_pkg::PVO_ST_IDLE: begin
          dout_d = `PVO_IDLE_BYTE;
          fv_d   = fv_q && !beat_q[`PVO_B_EOF];
          take   = 1'b1;
        end
        pvo_pkg::PVO_ST_SAV, pvo_pkg::PVO_ST_EAV: begin
          // Field bit is carried only in broadcast mode; raw has no SAV/EAV.
          dout_d = pvo_trs(idx_q, beat_q[`PVO_B_FIELD], st_q == pvo_pkg::PVO_ST_EAV);
          idx_d  = idx_q + 2'd1;
          if (idx_q == 2'd3) begin
            st_d = pvo_pkg::PVO_ST_DATA;
            take = (st_q == pvo_pkg::PVO_ST_EAV);
          end
        end
        pvo_pkg::PVO_ST_DATA: begin
          dout_d = pk.b[idx_q];
          lsb_d  = pk.lsb; // see RULE_10
          lv_d   = !bt; // see RULE_05
          fv_d   = !bt; // see RULE_09
          idx_d  = idx_q + 2'd1;
          if ({1'b0, idx_q} == pk.n - 3'd1) begin
            idx_d = 2'd0;
            pix_d = pix_q + `PVO_PIX_STEP;
            if (zoom_on && !rep_q) begin
              rep_d = 1'b1; // see RULE_11
            end else if (beat_q[`PVO_B_EOL]) begin
              st_d = bt ? pvo_pkg::PVO_ST_EAV : pvo_pkg::PVO_ST_IDLE;
            end else begin
              take = 1'b1;
            end
          end
        end
        default: st_d = pvo_pkg::PVO_ST_IDLE;
      endcase
      if (take) begin
        st_d = pvo_pkg::PVO_ST_IDLE;
        if (s_out.valid) begin
          beat_d = s_out.data;
          rep_d  = 1'b0;
          idx_d  = 2'd0;
          if (s_out.data[`PVO_B_SOL]) begin
            pix_d = 10'h0;
          end
          // Raw is always progressive: no embedded codes, field ignored.
          st_d = (bt && s_out.data[`PVO_B_SOL]) ? pvo_pkg::PVO_ST_SAV
                                                 : pvo_pkg::PVO_ST_DATA; // see RULE_03
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q   <= pvo_pkg::PVO_ST_IDLE;
      idx_q  <= 2'd0;
      rep_q  <= 1'b0;
      beat_q <= '0;
      pix_q  <= 10'h0;
      dout_q <= 8'h00;
      lsb_q  <= 2'h0;
      lv_q   <= 1'b0;
      fv_q   <= 1'b0;
    end else if (i_ce) begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      rep_q  <= rep_d;
      beat_q <= beat_d;
      pix_q  <= pix_d;
      dout_q <= dout_d;
      lsb_q  <= lsb_d;
      lv_q   <= lv_d;
      fv_q   <= fv_d;
    end
  end

  assign o_dout        = dout_q;
  assign o_dout_lsb    = lsb_q;
  assign o_line_valid  = lv_q;
  assign o_frame_valid = fv_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_emit(int i);
    adv && !restart && st_q == pvo_pkg::PVO_ST_DATA && idx_q == 2'(i);
  endsequence

  a_raw_pack_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_01
    (s_emit(1) ##0 (mode == pvo_pkg::PVO_MODE_RAW_PACK))
      |=> (o_dout == {6'h0, $past(beat_q[1:0])}))
    else $error("Second raw byte is not six zeros over bits 1..0.");
  a_raw_wide_bus: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_02
    (s_emit(0) ##0 (mode == pvo_pkg::PVO_MODE_RAW_WIDE))
      |=> (o_dout == $past(beat_q[9:2]) && o_dout_lsb == $past(beat_q[1:0])))
    else $error("Wide raw sample split wrongly.");
  a_raw_no_codes: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_03
    raw |-> st_q != pvo_pkg::PVO_ST_SAV)
    else $error("Raw output entered an embedded code.");
  a_sav_head: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_04
    (adv && !restart && st_q == pvo_pkg::PVO_ST_SAV && idx_q == 2'd0)
      |=> (o_dout == `PVO_TRS0 && !o_line_valid && !o_frame_valid))
    else $error("Timing code does not open with the all-ones byte.");
  a_lv_in_frame: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_05
    o_line_valid |-> o_frame_valid)
    else $error("Line valid outside frame valid.");
  a_rgb565_odd: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_07
    (s_emit(0) ##0 (mode == pvo_pkg::PVO_MODE_RGB && i_rgb_pack == 2'h0))
      |=> (o_dout == {$past(beat_q[31:27]), $past(beat_q[23:21])}))
    else $error("565 odd byte is not red then upper green.");
  a_cb_first: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_08
    (s_emit(0) ##0 (mode == pvo_pkg::PVO_MODE_YUV && !i_swap_cbcr && !i_swap_yc))
      |=> (o_dout == $past(beat_q[31:24])))
    else $error("Default order does not start with Cb.");
  a_sync_restart: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_15
    restart |=> (st_q == pvo_pkg::PVO_ST_IDLE && o_restart && !o_frame_valid)
      ##1 !o_restart)
    else $error("Frame sync did not restart timing for exactly one cycle.");
  a_width_even: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_14
    !o_active_width[0] && o_active_width >= `PVO_TV_W_MIN && o_active_width <= `PVO_TV_W)
    else $error("Active width is odd or out of range.");
  a_win_inside: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_11
    o_win_col <= `PVO_VGA_W - `PVO_ZOOM_W && o_win_row <= `PVO_VGA_H - `PVO_ZOOM_H)
    else $error("Zoom window leaves the VGA field.");
endmodule

//--- testbench/pvo_capture_model.sv
`timescale 1ns/1ps
module pvo_capture_model (
  // Control from the bench
  input  wire logic       i_run,
  input  wire logic       i_take_all,
  // Link pins
  input  wire logic [7:0] i_dout,
  input  wire logic [1:0] i_dout_lsb,
  input  wire logic       i_line_valid,
  input  wire logic       i_frame_valid,
  output logic            o_link_clk
);
  logic [11:0] cap_q[$];

  // --------------------------------------------------------------------------
  // Link clock
  // --------------------------------------------------------------------------
  // A started period is always finished, so the clock parks low between frames.
  // Stopping it is also how this receiver stalls the block.
  initial begin
    o_link_clk = 1'b0;
    #3;
    forever begin
      #40;
      if (i_run || o_link_clk) begin
        o_link_clk = ~o_link_clk;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Capture
  // --------------------------------------------------------------------------
  // Embedded-code streams carry no qualifiers, so the bench asks for every byte there.
  always @(posedge o_link_clk) begin
    if (i_take_all || (i_line_valid && i_frame_valid)) begin
      cap_q.push_back({i_frame_valid, i_line_valid, i_dout_lsb, i_dout});
    end
  end
endmodule

//--- testbench/pvo_formatter_tb_top.sv
`timescale 1ns/1ps
`include "pvo_consts.svh"
`define CHK(nm, e, g) chk(nm, e, g)

module pvo_formatter_tb_top;
  logic        mclk, rst_n, pv, ready, sof, eof, sol, eol, fld, scb, syc, zoom;
  logic        fsync, run, take_all, link_clk, lv, fv, restart;
  logic [31:0] pdata;
  logic [2:0]  mode;
  logic [1:0]  pack, lsb;
  logic [9:0]  pan_c, pan_r, wcol, wrow, awidth;
  logic [3:0]  ml, mr;
  logic [7:0]  dout;
  int          err_count, n_tests, cyc, rst_pulses, k;
  logic [31:0] yexp[4] = '{32'h11223344, 32'h33221144, 32'h22114433, 32'h22334411};
  logic [3:0]  mlt[4]  = '{4'hc, 4'h2, 4'he, 4'h0};
  logic [3:0]  mrt[4]  = '{4'he, 4'h6, 4'h2, 4'h0};
  logic [9:0]  wexp[4] = '{10'd694, 10'd712, 10'd704, `PVO_TV_W};

  pvo_formatter dut_u (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_pix_valid(pv), .o_pix_ready(ready), .i_pix_data(pdata),
    .i_pix_sof(sof), .i_pix_eof(eof), .i_pix_sol(sol), .i_pix_eol(eol), .i_pix_field(fld),
    .i_mode(mode), .i_rgb_pack(pack), .i_swap_cbcr(scb), .i_swap_yc(syc),
    .i_zoom_x2(zoom), .i_pan_col(pan_c), .i_pan_row(pan_r),
    .i_margin_left(ml), .i_margin_right(mr),
    .i_pixel_strobe_clock(link_clk), .i_frame_sync(fsync),
    .o_dout(dout), .o_dout_lsb(lsb), .o_line_valid(lv), .o_frame_valid(fv),
    .o_win_col(wcol), .o_win_row(wrow), .o_active_width(awidth), .o_restart(restart)
  );

  pvo_capture_model cap_u (
    .i_run(run), .i_take_all(take_all), .i_dout(dout), .i_dout_lsb(lsb),
    .i_line_valid(lv), .i_frame_valid(fv), .o_link_clk(link_clk)
  );

  // --------------------------------------------------------------------------
  // Clock, watchdog and restart counter
  // --------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Sampled on the falling edge so the registered pulse has settled.
  always @(negedge mclk) begin
    cyc++;
    if (restart === 1'b1) rst_pulses++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Holds the beat until the edge where ready is high; ready only moves on rising edges.
  task automatic send(input logic [31:0] d, input logic [3:0] fl);
    int n = 0;
    @(negedge mclk);
    pv = 1'b1;
    pdata = d;
    {sof, eof, sol, eol} = fl;
    while (ready !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    if (ready !== 1'b1) err_count++;
    @(negedge mclk);
    pv = 1'b0;
  endtask

  task automatic end_cap(input int links);
    repeat (links * 10) @(negedge mclk);
    run = 1'b0;
    repeat (30) @(negedge mclk);
  endtask

  task automatic one_beat(input logic [31:0] d, input int links);
    cap_u.cap_q.delete();
    run = 1'b1;
    send(d, 4'hf);
    end_cap(links);
  endtask

  task automatic chk_bytes(input string nm, input logic [31:0] e, input int n, input int b);
    `CHK("count", n + b, cap_u.cap_q.size() < n + b ? cap_u.cap_q.size() : n + b);
    for (int i = 0; i < n; i++) begin
      `CHK(nm, e[8*(n-1-i) +: 8], cap_u.cap_q[b+i][7:0]);
    end
  endtask

  task automatic zoom_chk(input logic z, input logic [9:0] c, r, ec, er);
    @(negedge mclk);
    {zoom, pan_c, pan_r} = {z, c, r};
    repeat (4) @(negedge mclk);
    `CHK("win_col", ec, wcol);
    `CHK("win_row", er, wrow);
  endtask

  function automatic logic [15:0] exp_rgb(input logic [1:0] p, input logic [7:0] r, g, b);
    case (p)
      2'h0:    return {r[7:3], g[7:2], b[7:3]};
      2'h1:    return {1'b0, r[7:3], g[7:3], b[7:3]};
      2'h2:    return {r[7:4], g[7:4], b[7:4], 4'h0};
      default: return {4'h0, r[7:4], g[7:4], b[7:4]};
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {rst_n, pv, sof, eof, sol, eol, fld, scb, syc, zoom, fsync, run, take_all} = '0;
    {pdata, mode, pack, pan_c, pan_r, ml, mr} = '0;
    {err_count, n_tests, cyc, rst_pulses} = '0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    `CHK("width_rst", `PVO_TV_W, awidth);
    `CHK("dout_rst", 8'h00, dout);
    $display("test reset done");
    mode = pvo_pkg::PVO_MODE_RGB;
    for (int p = 0; p < 4; p++) begin
      pack = 2'(p);
      one_beat(32'hb56c3a00, 8);
      chk_bytes("rgb", {16'h0, exp_rgb(pack, 8'hb5, 8'h6c, 8'h3a)}, 2, 0);
    end
    $display("test rgb done");
    mode = pvo_pkg::PVO_MODE_YUV;
    for (int i = 0; i < 4; i++) begin
      {syc, scb} = 2'(i);
      one_beat(32'h11223344, 10);
      chk_bytes("yuv", yexp[i], 4, 0);
    end
    {syc, scb} = 2'b00;
    $display("test yuv done");
    mode = pvo_pkg::PVO_MODE_RAW_PACK;
    fld = 1'b1;
    one_beat(32'h000002d7, 8);
    chk_bytes("raw_pack", 32'h0000b503, 2, 0);
    mode = pvo_pkg::PVO_MODE_RAW_WIDE;
    one_beat(32'h000002d7, 8);
    chk_bytes("raw_wide", 32'h000000b5, 1, 0);
    `CHK("raw_lsb", 2'h3, cap_u.cap_q[0][9:8]);
    fld = 1'b0;
    $display("test raw done");
    mode = pvo_pkg::PVO_MODE_BT656;
    take_all = 1'b1;
    one_beat(32'h11223344, 18);
    k = 0;
    while (k < cap_u.cap_q.size() && cap_u.cap_q[k][7:0] !== 8'hff) k++;
    chk_bytes("bt_sav", 32'hff000080, 4, k);
    chk_bytes("bt_data", 32'h11223344, 4, k + 4);
    chk_bytes("bt_eav", 32'hff00009d, 4, k + 8);
    foreach (cap_u.cap_q[i]) `CHK("bt_qual", 2'b00, cap_u.cap_q[i][11:10]);
    take_all = 1'b0;
    $display("test bt656 done");
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      {ml, mr} = {mlt[i], mrt[i]};
      repeat (4) @(negedge mclk);
      `CHK("width", wexp[i], awidth);
    end
    $display("test width done");
    zoom_chk(1'b1, 10'd500, 10'd300, `PVO_ZOOM_W, `PVO_ZOOM_H);
    zoom_chk(1'b1, 10'd100, 10'd50, 10'd100, 10'd50);
    mode = pvo_pkg::PVO_MODE_RGB;
    pack = pvo_pkg::PVO_RGB_565;
    one_beat(32'hb56c3a00, 10);
    chk_bytes("zoom_dup", {exp_rgb(2'h0, 8'hb5, 8'h6c, 8'h3a), exp_rgb(2'h0, 8'hb5, 8'h6c, 8'h3a)}, 4, 0);
    zoom_chk(1'b0, 10'd100, 10'd50, 10'd0, 10'd0);
    $display("test zoom done");
    cap_u.cap_q.delete();
    send(32'h12345600, 4'b1011);
    send(32'h9abcde00, 4'b0011);
    `CHK("buf_full", 1'b0, ready);
    run = 1'b1;
    send(32'h0f0f0f00, 4'b0011);
    end_cap(14);
    chk_bytes("buf_first", {16'h0, exp_rgb(2'h0, 8'h12, 8'h34, 8'h56)}, 2, 0);
    chk_bytes("buf_last", {16'h0, exp_rgb(2'h0, 8'h0f, 8'h0f, 8'h0f)}, 2, 4);
    $display("test buffer done");
    @(negedge mclk);
    {ml, mr} = {4'h2, 4'h6};
    `CHK("fv_high", 1'b1, fv);
    rst_pulses = 0;
    fsync = 1'b1;
    repeat (20) @(negedge mclk);
    fsync = 1'b0;
    `CHK("restart", 1, rst_pulses);
    `CHK("keep_width", 10'd712, awidth);
    `CHK("fv_low", 1'b0, fv);
    $display("test frame_sync done");
    print_verdict();
  end
endmodule
